// *** verilog/sms_pkg.sv ***
// constants, types and state encodings for the mode-button selector
// assumes a single 125 MHz system clock and a raw, bouncing button pin
// Notes on behaviour
// - menu entry only after boot done and LEDs dark, then five-second hold
// - the mode LEDs flash the pending choice code while the menu is active
// - entering the menu selects the no-change choice
// - each brief press in the menu advances the pending choice
// - five-second hold in the menu leaves it and commits the choice
// - LED codes: 001, 010, 011, 100; display codes S1 to S4
// - LEDs show current mode outside menu and pending choice inside it
// - outside the menu, without valid IP parameters show 01 and flash one LED
`default_nettype none
package sms_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int LONG_PRESS_MS = 5000;
   localparam int LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int FLASH_MS = 250;
   localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 30;

   typedef enum logic [1:0] {
      SEL_NO_CHANGE,
      SEL_DEFAULTS,
      SEL_PROTO_A,
      SEL_PROTO_B
   } sms_sel_t;

   typedef enum {
      ST_IDLE,
      ST_ARMED,
      ST_MENU,
      ST_MENU_HELD
   } sms_state_t;

   // leds: activity, speed, duplex
   typedef struct packed {
      logic activity_indicator;
      logic speed_indicator;
      logic duplex_indicator;
   } sms_leds_t;

   // display: two ascii characters
   typedef struct packed {
      logic [7:0] char_hi;
      logic [7:0] char_lo;
   } sms_disp_t;

   // one-cycle command to configuration logic
   typedef struct packed {
      logic restore_defaults;
      logic set_proto_a;
      logic set_proto_b;
   } sms_cmd_t;

   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam sms_cmd_t CMD_NONE = 3'h0;
   localparam sms_leds_t LEDS_OFF = 3'h0;

   function automatic sms_leds_t sel_leds(input sms_sel_t s);
      unique case (s)
         SEL_NO_CHANGE: sel_leds = 3'h1;
         SEL_DEFAULTS: sel_leds = 3'h2;
         SEL_PROTO_A: sel_leds = 3'h3;
         SEL_PROTO_B: sel_leds = 3'h4;
      endcase
   endfunction
endpackage
`default_nettype wire

// *** verilog/sms_selector.sv ***
// mode-button selector menu with led and display indication
// assumes MODE_BUTTON_I is a raw active-high pin; other inputs are on CLOCK_I
`timescale 1ns/10ps
`default_nettype none
module sms_selector #(
   parameter int LONG_CYC = sms_pkg::LONG_PRESS_CYC,
   parameter int DEB_CYC = sms_pkg::DEBOUNCE_CYC,
   parameter int FLASH_CYC = sms_pkg::FLASH_CYC
) (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic MODE_BUTTON_I,
   input wire logic BOOT_DONE_I,
   input wire logic IP_VALID_I,
   input wire sms_pkg::sms_leds_t MODE_LEDS_NORMAL_I,
   output sms_pkg::sms_leds_t MODE_LEDS_O,
   output sms_pkg::sms_disp_t DISPLAY_O,
   output sms_pkg::sms_cmd_t CMD_O,
   output logic MENU_ACTIVE_O
);
   // button path
   logic btn_meta;
   logic btn_sync;
   logic btn_deb;
   logic next_btn_deb;
   logic [sms_pkg::CNT_W-1:0] deb_cnt;
   logic [sms_pkg::CNT_W-1:0] next_deb_cnt;
   // flash timebase
   logic [sms_pkg::CNT_W-1:0] flash_cnt;
   logic [sms_pkg::CNT_W-1:0] next_flash_cnt;
   logic flash;
   logic next_flash;
   // press timing
   logic [sms_pkg::CNT_W-1:0] hold_cnt;
   logic [sms_pkg::CNT_W-1:0] next_hold_cnt;
   logic long_hit;
   logic short_release;
   // menu control
   sms_pkg::sms_state_t state;
   sms_pkg::sms_state_t next_state;
   sms_pkg::sms_sel_t sel;
   sms_pkg::sms_sel_t next_sel;
   sms_pkg::sms_cmd_t cmd;
   sms_pkg::sms_cmd_t next_cmd;
   logic menu_active;
   logic next_menu_active;
   // indication
   sms_pkg::sms_leds_t leds;
   sms_pkg::sms_leds_t next_leds;
   sms_pkg::sms_disp_t disp;
   sms_pkg::sms_disp_t next_disp;

   // both menu states show the same indication
   function automatic logic in_menu(input sms_pkg::sms_state_t s);
      in_menu = (s == sms_pkg::ST_MENU) || (s == sms_pkg::ST_MENU_HELD);
   endfunction

   // no change leaves every command bit low, so nothing is pulsed
   function automatic sms_pkg::sms_cmd_t commit_cmd(input sms_pkg::sms_sel_t s);
      commit_cmd = sms_pkg::CMD_NONE;
      commit_cmd.restore_defaults = (s == sms_pkg::SEL_DEFAULTS);
      commit_cmd.set_proto_a = (s == sms_pkg::SEL_PROTO_A);
      commit_cmd.set_proto_b = (s == sms_pkg::SEL_PROTO_B);
   endfunction

   // two-flop synchroniser; only btn_sync is read by logic
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         btn_meta <= 1'b0;
         btn_sync <= 1'b0;
      end else begin
         btn_meta <= MODE_BUTTON_I;
         btn_sync <= btn_meta;
      end
   end

   // a new level must stand for DEB_CYC cycles in a row to be taken
   always_comb begin
      next_deb_cnt = '0;
      next_btn_deb = btn_deb;
      if (btn_sync != btn_deb) begin
         if (deb_cnt >= sms_pkg::CNT_W'(DEB_CYC - 1)) begin
            next_btn_deb = btn_sync;
         end else begin
            next_deb_cnt = deb_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         btn_deb <= 1'b0;
         deb_cnt <= '0;
      end else begin
         btn_deb <= next_btn_deb;
         deb_cnt <= next_deb_cnt;
      end
   end

   // flash timebase shared by menu and missing-ip indication
   always_comb begin
      next_flash_cnt = flash_cnt + 1'b1;
      next_flash = flash;
      if (flash_cnt >= sms_pkg::CNT_W'(FLASH_CYC - 1)) begin
         next_flash_cnt = '0;
         next_flash = ~flash;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         flash_cnt <= '0;
         flash <= 1'b0;
      end else begin
         flash_cnt <= next_flash_cnt;
         flash <= next_flash;
      end
   end

   // hold counter saturates, so a very long hold still counts once
   always_comb begin
      next_hold_cnt = '0;
      if (btn_deb && hold_cnt < sms_pkg::CNT_W'(LONG_CYC)) begin
         next_hold_cnt = hold_cnt + 1'b1;
      end else if (btn_deb) begin
         next_hold_cnt = hold_cnt;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         hold_cnt <= '0;
      end else begin
         hold_cnt <= next_hold_cnt;
      end
   end

   assign long_hit = btn_deb && (hold_cnt == sms_pkg::CNT_W'(LONG_CYC - 1));
   // release of a counted press; a long one has already left the menu
   assign short_release = !btn_deb && (hold_cnt != '0);

   always_comb begin
      next_state = state;
      next_sel = sel;
      next_cmd = sms_pkg::CMD_NONE;
      unique case (state)
         // presses before boot or while leds lit are ignored until release
         sms_pkg::ST_IDLE: begin
            if (BOOT_DONE_I && !btn_deb && MODE_LEDS_NORMAL_I == sms_pkg::LEDS_OFF) begin
               next_state = sms_pkg::ST_ARMED;
            end
         end
         // boot lost while armed: wait for the entry conditions again
         sms_pkg::ST_ARMED: begin
            if (!BOOT_DONE_I) begin
               next_state = sms_pkg::ST_IDLE;
            end else if (long_hit) begin
               next_state = sms_pkg::ST_MENU_HELD;
               next_sel = sms_pkg::SEL_NO_CHANGE;
            end
         end
         sms_pkg::ST_MENU: begin
            if (long_hit) begin
               // commit on reaching the threshold, not on release
               next_state = sms_pkg::ST_IDLE;
               next_cmd = commit_cmd(sel);
            end else if (short_release) begin
               next_sel = sms_pkg::sms_sel_t'(sel + 2'h1); // wraps
            end
         end
         // entry hold must be released before presses count
         sms_pkg::ST_MENU_HELD: begin
            if (!btn_deb) begin
               next_state = sms_pkg::ST_MENU;
            end
         end
      endcase
      next_menu_active = in_menu(next_state);
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         state <= sms_pkg::ST_IDLE;
         sel <= sms_pkg::SEL_NO_CHANGE;
         cmd <= sms_pkg::CMD_NONE;
         menu_active <= 1'b0;
      end else begin
         state <= next_state;
         sel <= next_sel;
         cmd <= next_cmd;
         menu_active <= next_menu_active;
      end
   end

   // menu leds blank on the off phase; display stays steady so it remains readable
   always_comb begin
      next_leds = MODE_LEDS_NORMAL_I;
      next_disp = '{char_hi: sms_pkg::CH_SPACE, char_lo: sms_pkg::CH_SPACE};
      if (in_menu(state)) begin
         next_leds = flash ? sms_pkg::sel_leds(sel) : sms_pkg::LEDS_OFF;
         next_disp = '{char_hi: sms_pkg::CH_S, char_lo: sms_pkg::CH_1 + 8'(sel)};
      end else if (!IP_VALID_I) begin
         next_leds.activity_indicator = flash;
         next_disp = '{char_hi: sms_pkg::CH_0, char_lo: sms_pkg::CH_1};
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         leds <= sms_pkg::LEDS_OFF;
         disp <= '{char_hi: sms_pkg::CH_SPACE, char_lo: sms_pkg::CH_SPACE};
      end else begin
         leds <= next_leds;
         disp <= next_disp;
      end
   end

   assign MODE_LEDS_O = leds;
   assign DISPLAY_O = disp;
   assign CMD_O = cmd;
   assign MENU_ACTIVE_O = menu_active;
endmodule
`default_nettype wire

// *** tb/sms_selector_sva.sv ***
// checker for the mode-button selector ports
// assumes one clock domain, reset synchronous and active low
`timescale 1ns/10ps
`default_nettype none
module sms_selector_sva #(
   parameter int LONG_CYC = 40,
   parameter int DEB_CYC = 3,
   parameter int FLASH_CYC = 5
) (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic MODE_BUTTON_I,
   input wire logic BOOT_DONE_I,
   input wire logic IP_VALID_I,
   input wire sms_pkg::sms_leds_t MODE_LEDS_NORMAL_I,
   input wire sms_pkg::sms_leds_t MODE_LEDS_O,
   input wire sms_pkg::sms_disp_t DISPLAY_O,
   input wire sms_pkg::sms_cmd_t CMD_O,
   input wire logic MENU_ACTIVE_O
);
   localparam int FW = 2 * FLASH_CYC + 2;
   logic [2:0] out_q;
   logic [2:0] ip_q;
   // three settled cycles outside the menu before led checks apply
   always_ff @(posedge CLOCK_I) begin
      out_q <= {out_q[1:0], RST_B_I && !MENU_ACTIVE_O};
      ip_q <= {ip_q[1:0], IP_VALID_I};
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   entry_gate_a: assert property ($rose(MENU_ACTIVE_O) |-> $past(BOOT_DONE_I))
      else $error("menu entered before boot done");
   entry_hold_a: assert property ($rose(MENU_ACTIVE_O) |-> $past(MODE_BUTTON_I, 6))
      else $error("menu entered without a long hold");
   menu_code_a: assert property (MENU_ACTIVE_O && $past(MENU_ACTIVE_O, 2)
      |-> DISPLAY_O.char_hi == 8'h53 && (MODE_LEDS_O == 3'h0 || MODE_LEDS_O ==
      DISPLAY_O.char_lo[2:0] || MODE_LEDS_O == $past(DISPLAY_O.char_lo[2:0])))
      else $error("menu leds and display disagree");
   flash_on_a: assert property (MENU_ACTIVE_O |-> ##[0:FW] (MODE_LEDS_O != 3'h0 || !MENU_ACTIVE_O))
      else $error("menu leds stay dark");
   flash_off_a: assert property (MENU_ACTIVE_O |-> ##[0:FW] (MODE_LEDS_O == 3'h0 || !MENU_ACTIVE_O))
      else $error("menu leds do not flash");
   cmd_pulse_a: assert property (CMD_O != 3'h0 |=> CMD_O == 3'h0)
      else $error("command longer than one cycle");
   cmd_exit_a: assert property (CMD_O != 3'h0 |-> $past(MENU_ACTIVE_O) ##[0:2] !MENU_ACTIVE_O)
      else $error("command without leaving the menu");
   cmd_code_a: assert property (CMD_O != 3'h0 |->
      CMD_O == (3'h4 >> ($past(DISPLAY_O.char_lo[2:0]) - 3'h2)))
      else $error("command does not match the choice");
   no_ip_a: assert property (&out_q && !MENU_ACTIVE_O && ip_q == 3'h0 && !IP_VALID_I
      |-> DISPLAY_O == 16'h3031 && MODE_LEDS_O[1:0] == $past(MODE_LEDS_NORMAL_I[1:0]))
      else $error("missing address indication wrong");
   normal_leds_a: assert property (&out_q && !MENU_ACTIVE_O && &ip_q |->
      MODE_LEDS_O == $past(MODE_LEDS_NORMAL_I))
      else $error("leds do not follow normal indication");
   cover property ($rose(MENU_ACTIVE_O));
   cover property (CMD_O != 3'h0);
   cover property (DISPLAY_O == 16'h3031);
   cover property (CMD_O == 3'h1);
endmodule
bind sms_selector sms_selector_sva #(.LONG_CYC(LONG_CYC), .DEB_CYC(DEB_CYC),
   .FLASH_CYC(FLASH_CYC)) sva_inst (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
   .MODE_BUTTON_I(MODE_BUTTON_I), .BOOT_DONE_I(BOOT_DONE_I), .IP_VALID_I(IP_VALID_I),
   .MODE_LEDS_NORMAL_I(MODE_LEDS_NORMAL_I), .MODE_LEDS_O(MODE_LEDS_O),
   .DISPLAY_O(DISPLAY_O), .CMD_O(CMD_O), .MENU_ACTIVE_O(MENU_ACTIVE_O));
`default_nettype wire

// *** tb/sms_btn_model.sv ***
// mode pushbutton with contact bounce
// assumes press_i is driven on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module sms_btn_model (
   input wire logic clk_i,
   input wire logic press_i,
   output logic btn_o
);
   logic last = 1'b0;
   logic [1:0] bnc = 2'h0;
   initial btn_o = 1'b0;
   // one wrong-level glitch after every change tests the debounce
   always @(posedge clk_i) begin
      last <= press_i;
      bnc <= (press_i != last) ? 2'h2 : (bnc != 2'h0 ? bnc - 2'h1 : 2'h0);
      btn_o <= (bnc == 2'h1) ? !press_i : press_i;
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the mode-button selector
// assumes shortened counts: hold 40, debounce 3, flash 5 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic CLOCK_I = 1'b0, RST_B_I = 1'b0, BOOT_DONE_I = 1'b0, IP_VALID_I = 1'b1;
   logic press = 1'b0, btn, menu;
   sms_pkg::sms_leds_t leds_n = 3'h0, leds;
   sms_pkg::sms_disp_t disp;
   sms_pkg::sms_cmd_t cmd;
   int miscompares = 0, n_compared = 0;
   always #4 CLOCK_I = ~CLOCK_I;
   sms_btn_model sms_btn_model_inst (.clk_i(CLOCK_I), .press_i(press), .btn_o(btn));
   sms_selector #(.LONG_CYC(40), .DEB_CYC(3), .FLASH_CYC(5)) sms_selector_inst (
      .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .MODE_BUTTON_I(btn), .BOOT_DONE_I(BOOT_DONE_I),
      .IP_VALID_I(IP_VALID_I), .MODE_LEDS_NORMAL_I(leds_n), .MODE_LEDS_O(leds),
      .DISPLAY_O(disp), .CMD_O(cmd), .MENU_ACTIVE_O(menu));
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK_I);
   endtask
   task automatic hold(input int n);
      tick(1);
      press <= 1'b1;
      tick(n);
      press <= 1'b0;
      tick(12);
      #1;
   endtask
   task automatic t_enter;
      int on = 0, off = 0;
      hold(60);
      cmp(menu, 1'b0);
      tick(1);
      BOOT_DONE_I <= 1'b1;
      hold(10);
      hold(50);
      cmp(menu, 1'b1);
      cmp(disp, 16'h5331);
      repeat (12) begin
         tick(1);
         #1;
         on += (leds == 3'h1);
         off += (leds == 3'h0);
      end
      cmp({on > 0, off > 0}, 2'h3);
   endtask
   task automatic t_step;
      for (int i = 1; i <= 4; i++) begin
         hold(10);
         cmp(disp, {8'h53, 8'h31 + 8'(i % 4)});
      end
   endtask
   // long hold that swaps leds_n as it starts; counts the command pulses seen
   task automatic long_hold(input sms_pkg::sms_leds_t n, output logic [2:0] got, output int c);
      c = 0;
      got = 3'h0;
      tick(1);
      leds_n <= n;
      press <= 1'b1;
      repeat (80) begin
         tick(1);
         #1;
         if (cmd !== 3'h0) begin
            c++;
            got = cmd;
         end
      end
      tick(1);
      press <= 1'b0;
      tick(12);
      #1;
   endtask
   task automatic t_commit;
      int c;
      logic [2:0] got;
      hold(10);
      long_hold(3'h5, got, c);
      cmp(got, 3'h4);
      cmp(16'(c), 16'h1);
      cmp(menu, 1'b0);
      cmp(leds, 3'h5);
   endtask
   task automatic t_proto_b;
      int c;
      int on = 0;
      logic [2:0] got;
      tick(1);
      leds_n <= 3'h0;
      hold(50);
      cmp(menu, 1'b1);
      repeat (3) hold(10);
      cmp(disp, 16'h5334);
      repeat (12) begin
         tick(1);
         #1;
         on += (leds == 3'h4);
      end
      cmp(16'(on > 0), 16'h1);
      long_hold(3'h5, got, c);
      cmp(got, 3'h1);
      cmp(16'(c), 16'h1);
      cmp(menu, 1'b0);
   endtask
   task automatic t_no_ip;
      int on = 0, off = 0;
      tick(1);
      IP_VALID_I <= 1'b0;
      tick(4);
      #1;
      cmp(disp, 16'h3031);
      cmp(leds[1:0], 2'h1);
      repeat (12) begin
         tick(1);
         #1;
         on += leds[2];
         off += !leds[2];
      end
      cmp({on > 0, off > 0}, 2'h3);
   endtask
   initial begin
      tick(12);
      RST_B_I <= 1'b1;
      #1;
      cmp(disp, 16'h2020);
      t_enter();
      t_step();
      t_commit();
      t_proto_b();
      t_no_ip();
      tally_and_finish();
   end
endmodule
`default_nettype wire
